//--- fst_frame_seq.sv
// Purpose: Frame sequencing, restart and trigger control of a rolling-shutter readout
// Assumes: One clock, synchronous active-high reset, single-cycle register strobes
// Notes: Row and column counters model the read pointer; exposure modelled per frame
`timescale 1ns/100ps
module fst_frame_seq #(
  parameter int DW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_trigger,
  output logic [DW-1:0] o_rdata,
  output logic o_frame_valid,
  output logic o_line_valid,
  output logic o_frame_start,
  output logic o_exposure,
  output logic o_pll_clk_sel
);
  import fst_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fst_state_e state_q, state_d;
  logic [15:0] cfg_w_q [NUM_CFG];
  logic [15:0] cfg_p_q [NUM_CFG];
  logic [15:0] cfg_a_q [NUM_CFG];
  logic [15:0] row_q, row_d, col_q, col_d;
  logic [15:0] bub_rows_q;
  logic dirty_q, bub_p_q;
  logic restart_q, stream_q, single_q;
  logic trig_s1_q, trig_s2_q;
  logic [1:0] trig_cnt_q;
  logic [7:0] frame_cnt_q;
  logic fv_q, lv_q, fs_q, exp_q, pll_q;
  logic [DW-1:0] rdata_q;
  logic [3:0] cfg_idx;
  logic cfg_hit, ctrl_wr;
  logic [15:0] line_len, coarse, win_cols, win_rows, frame_rows, exp_start;
  logic row_end, frame_end, lead_end, trig_ok, run_video, restart_go, bnd;
  logic start_ok;

  assign cfg_idx = i_addr - REG_CFG_FIRST;
  assign cfg_hit = i_wr && (i_addr >= REG_CFG_FIRST) && (i_addr <= REG_CFG_LAST);
  assign ctrl_wr = i_wr && (i_addr == REG_CTRL);

  assign line_len = cfg_a_q[CFG_LINE_LEN];
  assign coarse = cfg_a_q[CFG_COARSE];
  assign win_cols = cfg_a_q[CFG_X_END] - cfg_a_q[CFG_X_START] + 16'h0001;
  assign win_rows = cfg_a_q[CFG_Y_END] - cfg_a_q[CFG_Y_START] + 16'h0001;
  assign frame_rows = cfg_a_q[CFG_FRAME_LEN] + bub_rows_q;
  assign exp_start = (frame_rows > coarse) ? frame_rows - coarse : 16'h0000;

  assign row_end = (col_q >= line_len - 16'h0001);
  assign frame_end = row_end && (row_q + 16'h0001 >= frame_rows);
  // Zero exposure still costs one lead row so the frame always starts
  assign lead_end = row_end && (row_q + 16'h0001 >= coarse);
  assign trig_ok = (trig_cnt_q == TRIG_HOLD_CYCLES) && !fv_q;
  assign run_video = stream_q || trig_s2_q;
  assign restart_go = restart_q && ((state_q == ST_STANDBY) || row_end);
  // Fixed latency from qualified trigger keeps sharing sensors in step
  assign start_ok = single_q ? trig_ok : (stream_q || trig_ok);

  // ----------------------------------------------------------------
  // Trigger synchroniser and level qualifier
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
    end else begin
      trig_s1_q <= i_trigger;
      trig_s2_q <= trig_s1_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_cnt_q <= 2'h0;
    end else if (!trig_s2_q) begin
      trig_cnt_q <= 2'h0;
    end else if (trig_cnt_q != TRIG_HOLD_CYCLES) begin
      trig_cnt_q <= trig_cnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      stream_q <= 1'b0;
      single_q <= 1'b0;
    end else if (ctrl_wr) begin
      stream_q <= i_wdata[CTRL_STREAM_BIT];
      single_q <= i_wdata[CTRL_SINGLE_BIT];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      restart_q <= 1'b0;
    end else if (ctrl_wr && i_wdata[CTRL_RESTART_BIT]) begin
      restart_q <= 1'b1;
    end else if (restart_go) begin
      restart_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pll_q <= 1'b0;
    end else begin
      pll_q <= stream_q;
    end
  end

  // ----------------------------------------------------------------
  // Frame-synchronised fields: written, pending, active
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cfg_w_q[CFG_X_START] <= RST_X_START;
      cfg_w_q[CFG_X_END] <= RST_X_END;
      cfg_w_q[CFG_Y_START] <= RST_Y_START;
      cfg_w_q[CFG_Y_END] <= RST_Y_END;
      cfg_w_q[CFG_FRAME_LEN] <= RST_FRAME_LEN;
      cfg_w_q[CFG_LINE_LEN] <= RST_LINE_LEN;
      cfg_w_q[CFG_COARSE] <= RST_COARSE;
      cfg_w_q[CFG_FINE] <= RST_FINE;
      cfg_w_q[CFG_READ_MODE] <= RST_READ_MODE;
    end else if (cfg_hit) begin
      cfg_w_q[cfg_idx] <= i_wdata[15:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_p_q[i] <= 16'h0000;
        cfg_a_q[i] <= 16'h0000;
      end
      cfg_p_q[CFG_X_END] <= RST_X_END;
      cfg_a_q[CFG_X_END] <= RST_X_END;
      cfg_p_q[CFG_Y_END] <= RST_Y_END;
      cfg_a_q[CFG_Y_END] <= RST_Y_END;
      cfg_p_q[CFG_FRAME_LEN] <= RST_FRAME_LEN;
      cfg_a_q[CFG_FRAME_LEN] <= RST_FRAME_LEN;
      cfg_p_q[CFG_LINE_LEN] <= RST_LINE_LEN;
      cfg_a_q[CFG_LINE_LEN] <= RST_LINE_LEN;
      cfg_p_q[CFG_COARSE] <= RST_COARSE;
      cfg_a_q[CFG_COARSE] <= RST_COARSE;
    end else if (restart_go) begin
      cfg_p_q <= cfg_w_q;
      cfg_a_q <= cfg_w_q;
    end else if (bnd) begin
      cfg_p_q <= cfg_w_q;
      cfg_a_q <= cfg_p_q;
    end
  end

  // ----------------------------------------------------------------
  // Blanking bubble after video-mode writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dirty_q <= 1'b0;
      bub_p_q <= 1'b0;
      bub_rows_q <= 16'h0000;
    end else begin
      if (cfg_hit && !single_q && (state_q != ST_STANDBY)) begin
        dirty_q <= 1'b1;
      end else if (bnd || restart_go) begin
        dirty_q <= 1'b0;
      end
      if (restart_go) begin
        bub_p_q <= 1'b0;
        bub_rows_q <= 16'h0000;
      end else if (bnd) begin
        bub_p_q <= dirty_q;
        // Shutter restarts: one frame padded by the new exposure rows
        bub_rows_q <= bub_p_q ? cfg_p_q[CFG_COARSE] : 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    row_d = row_q;
    col_d = row_end ? 16'h0000 : col_q + 16'h0001;
    bnd = 1'b0;
    unique case (state_q)
      ST_STANDBY: begin
        col_d = 16'h0000;
        if (!restart_q && start_ok) begin
          state_d = ST_EXPOSE;
          row_d = 16'h0000;
        end
      end
      ST_EXPOSE: begin
        if (restart_go) begin
          state_d = single_q ? ST_STANDBY : ST_EXPOSE;
          row_d = 16'h0000;
        end else if (lead_end) begin
          state_d = ST_FRAME;
          row_d = 16'h0000;
          bnd = 1'b1;
        end else if (row_end) begin
          row_d = row_q + 16'h0001;
        end
      end
      ST_FRAME: begin
        if (restart_go) begin
          state_d = single_q ? ST_STANDBY : ST_EXPOSE;
          row_d = 16'h0000;
        end else if (frame_end) begin
          row_d = 16'h0000;
          if (single_q) begin
            state_d = trig_ok ? ST_EXPOSE : ST_STANDBY;
          end else if (run_video) begin
            bnd = 1'b1;
          end else begin
            state_d = ST_STANDBY;
          end
        end else if (row_end) begin
          row_d = row_q + 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_q <= ST_STANDBY;
      row_q <= 16'h0000;
      col_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  // ----------------------------------------------------------------
  // Timing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fv_q <= 1'b0;
      lv_q <= 1'b0;
      fs_q <= 1'b0;
      exp_q <= 1'b0;
      frame_cnt_q <= 8'h00;
    end else begin
      fv_q <= (state_d == ST_FRAME) && (row_d < win_rows);
      lv_q <= (state_d == ST_FRAME) && (row_d < win_rows) && (col_d < win_cols);
      fs_q <= bnd;
      // Lead rows, or video tail rows that expose the next frame
      exp_q <= (state_d == ST_EXPOSE) ||
               ((state_d == ST_FRAME) && !single_q && run_video && (row_d >= exp_start));
      if (bnd) begin
        frame_cnt_q <= frame_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port: data valid only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_rd) begin
      rdata_q <= '0;
    end else if (i_addr == REG_CTRL) begin
      rdata_q <= '0;
      rdata_q[CTRL_RESTART_BIT] <= restart_q;
      rdata_q[CTRL_STREAM_BIT] <= stream_q;
      rdata_q[CTRL_SINGLE_BIT] <= single_q;
    end else if (i_addr == REG_STATUS) begin
      rdata_q <= '0;
      rdata_q[STAT_FV_BIT] <= fv_q;
      rdata_q[STAT_EXPOSE_BIT] <= exp_q;
      rdata_q[STAT_TRIG_OK_BIT] <= trig_ok;
      rdata_q[STAT_ACTIVE_BIT] <= (state_q != ST_STANDBY);
      rdata_q[STAT_CNT_LSB +: 8] <= frame_cnt_q;
    end else if (cfg_hit || ((i_addr >= REG_CFG_FIRST) && (i_addr <= REG_CFG_LAST))) begin
      rdata_q <= DW'(cfg_w_q[cfg_idx]);
    end else begin
      rdata_q <= '0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_frame_valid = fv_q;
  assign o_line_valid = lv_q;
  assign o_frame_start = fs_q;
  assign o_exposure = exp_q;
  assign o_pll_clk_sel = pll_q;

endmodule

//--- fst_pkg.sv
// Purpose: Shared constants and types for the frame sequencing and trigger block
// Assumes: Register port with 4-bit word address and 16-bit data
// Notes: Register offsets and reset values are set here once
package fst_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CFG_FIRST = 4'h2;
  localparam logic [3:0] REG_CFG_LAST = 4'hA;
  localparam int NUM_CFG = 9;

  // Frame-synchronised field indices, offset from REG_CFG_FIRST
  localparam int CFG_X_START = 0;
  localparam int CFG_X_END = 1;
  localparam int CFG_Y_START = 2;
  localparam int CFG_Y_END = 3;
  localparam int CFG_FRAME_LEN = 4;
  localparam int CFG_LINE_LEN = 5;
  localparam int CFG_COARSE = 6;
  localparam int CFG_FINE = 7;
  localparam int CFG_READ_MODE = 8;

  // ----------------------------------------------------------------
  // Control and status bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_STREAM_BIT = 2;
  localparam int CTRL_SINGLE_BIT = 3;
  localparam int STAT_FV_BIT = 0;
  localparam int STAT_EXPOSE_BIT = 1;
  localparam int STAT_TRIG_OK_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 3;
  localparam int STAT_CNT_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values of the frame-synchronised fields
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_X_START = 16'h0000;
  localparam logic [15:0] RST_X_END = 16'h001F;
  localparam logic [15:0] RST_Y_START = 16'h0000;
  localparam logic [15:0] RST_Y_END = 16'h000F;
  localparam logic [15:0] RST_FRAME_LEN = 16'h0018;
  localparam logic [15:0] RST_LINE_LEN = 16'h0040;
  localparam logic [15:0] RST_COARSE = 16'h0004;
  localparam logic [15:0] RST_FINE = 16'h0000;
  localparam logic [15:0] RST_READ_MODE = 16'h0000;

  // Consecutive high samples that qualify the trigger
  localparam logic [1:0] TRIG_HOLD_CYCLES = 2'h3;

  typedef enum logic [1:0] {ST_STANDBY, ST_EXPOSE, ST_FRAME} fst_state_e;

endpackage

//--- fst_frame_seq_sva.sv
// Purpose: Port-level checks of frame sequencing and trigger control
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to the design from the bench top file
`timescale 1ns/100ps
module fst_frame_seq_sva
  import fst_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_trigger,
  input wire logic [15:0] o_rdata,
  input wire logic o_frame_valid,
  input wire logic o_line_valid,
  input wire logic o_frame_start,
  input wire logic o_exposure,
  input wire logic o_pll_clk_sel
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_ctrl_wr;
    i_wr && i_addr == REG_CTRL;
  endsequence
  sequence s_lone_ctrl_wr;
    s_ctrl_wr ##1 !(i_wr && i_addr == REG_CTRL);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rdata_idle_zero:
    assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_start_one_cycle:
    assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  a_start_opens_fv:
    assert property (o_frame_start |-> o_frame_valid && !$past(o_frame_valid))
    else $error("frame start without frame valid rising");
  a_fv_needs_start:
    assert property ($rose(o_frame_valid) |-> o_frame_start)
    else $error("frame valid rose without frame start");
  a_lv_inside_fv:
    assert property (o_line_valid |-> o_frame_valid)
    else $error("line valid outside frame valid");
  a_fv_holds_row:
    assert property (o_frame_start |=> o_frame_valid [*8])
    else $error("frame valid dropped early");
  a_blank_holds_row:
    assert property ($fell(o_frame_valid) |-> !o_frame_valid [*8])
    else $error("vertical blanking too short");
  a_pll_follows_stream:
    assert property (s_lone_ctrl_wr |=> o_pll_clk_sel == $past(i_wdata[CTRL_STREAM_BIT], 2))
    else $error("clock select does not follow stream bit");
  a_expose_ends_start:
    assert property (o_frame_start |=> !o_exposure)
    else $error("exposure still high after readout start");
endmodule

//--- fst_host_model.sv
// Purpose: Host side trigger driver for the frame sequencing block
// Assumes: Bench sets hold and release-on-stream levels
// Notes: Trigger is a registered level, never an edge
`timescale 1ns/100ps
module fst_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_hold,
  input wire logic i_release_on_stream,
  input wire logic i_pll_clk_sel,
  output logic o_trigger
);
  // Drop trigger once streaming shows, for continuous mode
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_trigger <= 1'b0;
    end else begin
      o_trigger <= i_hold && !(i_release_on_stream && i_pll_clk_sel);
    end
  end
endmodule

//--- fst_frame_seq_bench.sv
// Purpose: Self-checking bench of frame sequencing and trigger control
// Assumes: Default window 32x16, frame 24 rows of 64 clocks
// Notes: Frame lengths measured between frame start pulses
`timescale 1ns/100ps
module fst_frame_seq_bench;
  import fst_pkg::*;
  localparam logic [3:0] A_COARSE = REG_CFG_FIRST + 4'(CFG_COARSE);
  localparam logic [3:0] A_X_END = REG_CFG_FIRST + 4'(CFG_X_END);
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic hold = 1'b0;
  logic rel = 1'b0;
  logic i_trigger, o_frame_valid, o_line_valid, o_frame_start, o_exposure, o_pll_clk_sel;
  logic [15:0] o_rdata;
  logic [15:0] v;
  logic [15:0] rst_tbl [NUM_CFG] = '{RST_X_START, RST_X_END, RST_Y_START, RST_Y_END,
    RST_FRAME_LEN, RST_LINE_LEN, RST_COARSE, RST_FINE, RST_READ_MODE};
  int n_mismatch = 0;
  int checks = 0;
  int n;
  int n_lv;
  int n_exp;
  always #5 i_ref_clk = ~i_ref_clk;

  fst_frame_seq dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_trigger(i_trigger),
    .o_rdata(o_rdata), .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
    .o_frame_start(o_frame_start), .o_exposure(o_exposure), .o_pll_clk_sel(o_pll_clk_sel));
  fst_host_model host_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hold(hold),
    .i_release_on_stream(rel), .i_pll_clk_sel(o_pll_clk_sel), .o_trigger(i_trigger));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic wait_start(input int lim);
    n = 0;
    n_lv = 0;
    n_exp = 0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
      if (o_line_valid === 1'b1) n_lv++;
      if (o_exposure === 1'b1) n_exp++;
    end while (o_frame_start !== 1'b1 && n < lim);
  endtask
  // Write lands in frame N, bubble shows in frame N+2
  task automatic bubble(input logic [3:0] a, input logic [15:0] d, input logic [15:0] len);
    wait_start(2000);
    wr(a, d);
    wait_start(2000);
    wait_start(2000);
    check("frame_before", n[15:0], 16'd1536);
    wait_start(2200);
    check("frame_bubble", n[15:0], len);
    wait_start(2000);
    check("frame_after", n[15:0], 16'd1536);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(REG_CTRL, v);
    check("ctrl_reset", v, 16'h0000);
    rd(4'hB, v);
    check("unmapped", v, 16'h0000);
    for (int k = 0; k < NUM_CFG; k++) begin
      rd(REG_CFG_FIRST + 4'(k), v);
      check("cfg_reset", v, rst_tbl[k]);
    end
    wr(REG_CFG_FIRST + 4'(CFG_FINE), 16'h0005);
    rd(REG_CFG_FIRST + 4'(CFG_FINE), v);
    check("readback", v, 16'h0005);
    // Single frame: a two-cycle glitch must not qualify
    wr(REG_CTRL, 16'h0008);
    hold <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    hold <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge i_ref_clk);
      #1;
      if (o_exposure !== 1'b0) n++;
    end
    check("glitch_expose", n[15:0], 16'h0000);
    hold <= 1'b1;
    n = 0;
    while (o_exposure !== 1'b1 && n < 50) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check("trig_latency", {15'h0000, n > 3 && n < 16}, 16'h0001);
    wait_start(600);
    check("single_frame", {15'h0000, n < 600}, 16'h0001);
    hold <= 1'b0;
    wait_start(4000);
    check("no_new_frame", n[15:0], 16'd4000);
    rd(REG_STATUS, v);
    check("single_idle", {15'h0000, v[STAT_ACTIVE_BIT]}, 16'h0000);
    // Continuous trigger released once streaming
    wr(REG_CTRL, 16'h0000);
    rel <= 1'b1;
    hold <= 1'b1;
    wait_start(800);
    check("cont_first", {15'h0000, n < 800}, 16'h0001);
    wr(REG_CTRL, 16'h0004);
    wait_start(1600);
    wait_start(1600);
    check("cont_len", n[15:0], 16'd1536);
    check("lv_count", n_lv[15:0], 16'd512);
    check("expose_len", n_exp[15:0], 16'd256);
    check("pll_sel", {15'h0000, o_pll_clk_sel}, 16'h0001);
    check("trig_released", {15'h0000, i_trigger}, 16'h0000);
    rel <= 1'b0;
    wr(REG_CTRL, 16'h0000);
    wait_start(1600);
    wait_start(1600);
    check("held_running", n[15:0], 16'd1536);
    hold <= 1'b0;
    repeat (4000) @(posedge i_ref_clk);
    rd(REG_STATUS, v);
    check("video_idle", {15'h0000, v[STAT_ACTIVE_BIT]}, 16'h0000);
    // Video bubbles, also when the value is unchanged
    wr(REG_CTRL, 16'h0004);
    bubble(A_COARSE, 16'h0006, 16'd1920);
    bubble(A_X_END, RST_X_END, 16'd1920);
    // Restart mid-frame applies new exposure at once
    wait_start(2000);
    repeat (100) @(posedge i_ref_clk);
    wr(A_COARSE, 16'h0002);
    wr(REG_CTRL, 16'h0006);
    n = 0;
    while (o_frame_valid !== 1'b0 && n < 200) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    check("restart_cut", {15'h0000, n <= 64}, 16'h0001);
    wait_start(800);
    check("restart_gap", {15'h0000, n > 120 && n < 140}, 16'h0001);
    rd(REG_CTRL, v);
    check("restart_clear", v, 16'h0004);
    report_and_stop();
  end

  // Tests need about 31400 cycles
  initial begin
    #500000;
    n_mismatch++;
    report_and_stop();
  end
endmodule

bind fst_frame_seq fst_frame_seq_sva chk_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_trigger(i_trigger),
  .o_rdata(o_rdata), .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
  .o_frame_start(o_frame_start), .o_exposure(o_exposure), .o_pll_clk_sel(o_pll_clk_sel));
